// *** tb/cfg_host_model.sv ***
// Management host and configuration loader model for the register port
`timescale 1ns/1ps
`default_nettype none
module cfg_host_model (
  input wire logic clk_i,
  output logic [7:0] addr_o,
  output logic wr_o,
  output logic [7:0] wdata_o,
  output logic rd_o,
  output logic load_o,
  output logic [7:0] laddr_o,
  output logic [7:0] ldata_o,
  input wire logic [7:0] rdata_i,
  input wire logic rvalid_i
);
  initial begin
    addr_o = 8'h00;
    wr_o = 1'b0;
    wdata_o = 8'h00;
    rd_o = 1'b0;
    load_o = 1'b0;
    laddr_o = 8'h00;
    ldata_o = 8'h00;
  end

  // One request held for one edge, answer taken one edge later
  task automatic xfer(input logic w, r, l, input logic [7:0] a, d, la, ld, output logic [7:0] q, output logic v);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= (a == 8'h13) ? 8'h00 : d;
    laddr_o <= la;
    ldata_o <= (la == 8'h13) ? 8'h00 : ld;
    wr_o <= w;
    rd_o <= r;
    load_o <= l;
    @(posedge clk_i);
    wr_o <= 1'b0;
    rd_o <= 1'b0;
    load_o <= 1'b0;
    // Released lines show the inverse of the requested a, d, la and ld, not of the zeroed 0x13 data
    addr_o <= ~a;
    wdata_o <= ~d;
    laddr_o <= ~la;
    ldata_o <= ~ld;
    @(posedge clk_i);
    q = rdata_i;
    v = rvalid_i;
  endtask

  // Write then read of one address on consecutive edges
  task automatic wr_then_rd(input logic [7:0] a, d, output logic [7:0] q);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= (a == 8'h13) ? 8'h00 : d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
    @(posedge clk_i);
    q = rdata_i;
  endtask
endmodule // cfg_host_model
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench for the repeater channel configuration registers
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ovr_th = 1'b0;
  logic ovr_idle = 1'b0;
  logic pin = 1'b0;
  wire logic [7:0] addr, wdata, laddr, ldata, rdata, eq;
  wire logic wr, rd, load, rvalid, slow, from_reg, sd, auto_i, force_i;
  wire logic [2:0] deemphasis_level;
  wire logic [1:0] as_l, de_l;
  int miscompares = 0;
  int checked = 0;
  int mem [256];
  integer seed = 32'h2C40F12B;

  initial forever #5 clk = ~clk;

  cfg_host_model cfg_host_model_inst (.clk_i(clk), .addr_o(addr), .wr_o(wr), .wdata_o(wdata), .rd_o(rd),
    .load_o(load), .laddr_o(laddr), .ldata_o(ldata), .rdata_i(rdata), .rvalid_i(rvalid));

  repeater_channel_config_regs repeater_channel_config_regs_inst (.SYS_CLK_I(clk), .RST_I(rst),
    .REG_ADDR_I(addr), .REG_WR_I(wr), .REG_WDATA_I(wdata), .REG_RD_I(rd), .REG_RDATA_O(rdata),
    .REG_RVALID_O(rvalid), .LOAD_WR_I(load), .LOAD_ADDR_I(laddr), .LOAD_DATA_I(ldata),
    .OVR_IDLE_THRESHOLD_I(ovr_th), .OVR_IDLE_I(ovr_idle), .SIGNAL_DETECT_LEVEL_PIN_I(pin),
    .DEEMPHASIS_LEVEL_A_O(deemphasis_level), .SLOW_OUT_OF_BAND_DETECT_A_O(slow), .IDLE_ASSERT_LEVEL_A_O(as_l),
    .IDLE_DEASSERT_LEVEL_A_O(de_l), .IDLE_LEVEL_FROM_REG_A_O(from_reg), .SIGNAL_DETECT_LEVEL_O(sd),
    .AUTO_IDLE_B_O(auto_i), .FORCE_IDLE_B_O(force_i), .EQ_BOOST_B_O(eq));

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk_out(input string what, input int exp, input logic [7:0] got);
    checked++;
    if (got !== exp[7:0]) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp[7:0], got);
    end
  endtask

  task automatic chk_rd(input logic [7:0] a);
    logic [7:0] q;
    logic v;
    cfg_host_model_inst.xfer(1'b0, 1'b1, 1'b0, a, 8'h00, 8'h00, 8'h00, q, v);
    chk_out("read valid", 1, {7'h00, v});
    chk_out("read data", mem[a], q);
  endtask

  function automatic void put(input logic [7:0] a, d);
    if (a == 8'h11)
      mem[a] = {3'b100, d[4:0]};
    else if (a == 8'h13)
      mem[a] = 0;
    else if (a >= 8'h12 && a <= 8'h16)
      mem[a] = d;
  endfunction

  task automatic wr_reg(input logic [7:0] a, d, input logic l, b);
    logic [7:0] q;
    logic v;
    cfg_host_model_inst.xfer(b | ~l, 1'b0, l, a, ~d, a, d, q, v);
    put(a, (b | ~l) ? ~d : d);
  endtask

  task automatic wr_rd_boost(input logic [7:0] d);
    logic [7:0] q;
    cfg_host_model_inst.wr_then_rd(8'h16, d, q);
    put(8'h16, d);
    chk_out("boost readback", mem[8'h16], q);
  endtask

  task automatic check_outs;
    repeat (3) @(posedge clk);
    chk_out("deemphasis", mem[8'h11] & 7, {5'h00, deemphasis_level});
    chk_out("slow_out_of_band_detect", mem[8'h12] >> 7, {7'h00, slow});
    chk_out("assert level", ovr_th ? (mem[8'h12] >> 2) & 3 : 0, {6'h00, as_l});
    chk_out("deassert level", ovr_th ? mem[8'h12] & 3 : 0, {6'h00, de_l});
    chk_out("level source", ovr_th, {7'h00, from_reg});
    chk_out("auto idle", ovr_idle & (mem[8'h15] >> 5), {7'h00, auto_i});
    chk_out("force idle", ovr_idle & (mem[8'h15] >> 4), {7'h00, force_i});
    chk_out("eq boost", mem[8'h16], eq);
  endtask

  task automatic reset_dut;
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 256; a++)
      mem[a] = 0;
    mem[8'h11] = 32'h82;
    mem[8'h16] = 32'h2F;
  endtask

  task automatic read_all;
    chk_rd(8'h00);
    chk_rd(8'hFF);
    for (int a = 8'h10; a <= 8'h17; a++)
      chk_rd(a[7:0]);
  endtask

  initial begin
    reset_dut();
    read_all();
    check_outs();
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      wr_reg(8'h11, 8'({$random(seed)} & 8'hF8 | i[7:0]), 1'b0, 1'b0);
      check_outs();
      chk_rd(8'h11);
    end
    $display("test deemphasis done");
    for (int i = 0; i < 32; i++) begin
      ovr_th <= i[4];
      ovr_idle <= i[0] ^ i[4];
      wr_reg(8'h12, 8'({$random(seed)} & 8'hF0 | i[3:0]), 1'b0, 1'b0);
      wr_reg(8'h15, 8'($random(seed)), 1'b0, 1'b0);
      wr_reg(8'h16, 8'($random(seed)), 1'b0, 1'b0);
      wr_reg(8'h13, 8'($random(seed)), 1'b0, 1'b0);
      wr_reg(8'h14, 8'($random(seed)), 1'b0, 1'b0);
      wr_reg(8'h17 + i[7:0], 8'($random(seed)), 1'b0, 1'b0);
      check_outs();
    end
    read_all();
    $display("test fields done");
    for (int i = 8'h11; i <= 8'h16; i++) begin
      wr_reg(i[7:0], 8'($random(seed)), 1'b1, 1'b0);
      wr_reg(i[7:0], 8'($random(seed)), 1'b1, 1'b1);
    end
    read_all();
    check_outs();
    $display("test load done");
    repeat (4) wr_rd_boost(8'($random(seed)));
    check_outs();
    $display("test readback done");
    repeat (2) begin
      pin <= ~pin;
      repeat (4) @(posedge clk);
      chk_out("pin level", pin, {7'h00, sd});
    end
    $display("test pin done");
    reset_dut();
    read_all();
    check_outs();
    $display("test second reset done");
    test_done();
  end

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    test_done();
  end
endmodule // testbench
`default_nettype wire

// *** verilog/idle_gate_if.sv ***
// Interface between the register slice and the idle override gate
`timescale 1ns/1ps
`default_nettype none
interface idle_gate_if;
  logic ovr_th;
  logic ovr_idle;
  logic pin_level;
  logic [1:0] assert_raw;
  logic [1:0] deassert_raw;
  logic auto_raw;
  logic force_raw;
  logic [1:0] assert_lvl;
  logic [1:0] deassert_lvl;
  logic from_reg;
  logic pin_out;
  logic auto_idle;
  logic force_idle;
  modport src (
    output ovr_th, ovr_idle, pin_level, assert_raw, deassert_raw, auto_raw, force_raw,
    input assert_lvl, deassert_lvl, from_reg, pin_out, auto_idle, force_idle
  );
  modport gate (
    input ovr_th, ovr_idle, pin_level, assert_raw, deassert_raw, auto_raw, force_raw,
    output assert_lvl, deassert_lvl, from_reg, pin_out, auto_idle, force_idle
  );
endinterface
`default_nettype wire

// *** verilog/idle_override_gate.sv ***
// Gates idle thresholds and idle control by the global override bits
`timescale 1ns/1ps
`default_nettype none
module idle_override_gate (
  input wire logic clk_i,
  input wire logic rst_i,
  idle_gate_if.gate g
);
  wire [1:0] next_assert_lvl;
  wire [1:0] next_deassert_lvl;
  wire next_auto_idle;
  wire next_force_idle;

  // Register fields only count while the override is set
  assign next_assert_lvl = g.ovr_th ? g.assert_raw : repeater_cfg_pkg::LEVEL_DEFAULT; // [R3] [R10]
  assign next_deassert_lvl = g.ovr_th ? g.deassert_raw : repeater_cfg_pkg::LEVEL_DEFAULT; // [R4] [R10]
  assign next_auto_idle = g.ovr_idle & g.auto_raw; // [R5] [R11]
  assign next_force_idle = g.ovr_idle & g.force_raw; // [R6] [R11]

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      g.assert_lvl <= repeater_cfg_pkg::LEVEL_DEFAULT;
      g.deassert_lvl <= repeater_cfg_pkg::LEVEL_DEFAULT;
      g.from_reg <= 1'b0;
      g.pin_out <= 1'b0;
      g.auto_idle <= 1'b0;
      g.force_idle <= 1'b0;
    end else begin
      g.assert_lvl <= next_assert_lvl;
      g.deassert_lvl <= next_deassert_lvl;
      g.from_reg <= g.ovr_th; // [R10]
      g.pin_out <= g.pin_level;
      g.auto_idle <= next_auto_idle;
      g.force_idle <= next_force_idle;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_assert_gate: assert property (g.ovr_th |=> g.assert_lvl == $past(g.assert_raw)) // [R3]
    else $error("assert level not taken from register under override");
  a_deassert_gate: assert property (g.ovr_th |=> g.deassert_lvl == $past(g.deassert_raw)) // [R4]
    else $error("de-assert level not taken from register under override");
  a_pin_control: assert property (!g.ovr_th |=> !g.from_reg && g.assert_lvl == 2'h0 // [R10]
    && g.deassert_lvl == 2'h0)
    else $error("threshold fields leak without override");
  a_auto_gate: assert property (g.auto_idle == $past(g.ovr_idle && g.auto_raw)) // [R5]
    else $error("auto idle not gated by idle override");
  a_force_gate: assert property (!g.ovr_idle |=> !g.force_idle && !g.auto_idle) // [R11]
    else $error("idle outputs active without override");
  a_force_follow: assert property (g.ovr_idle && g.force_raw |=> g.force_idle) // [R6]
    else $error("forced idle not applied under override");
endmodule // idle_override_gate
`default_nettype wire

// *** verilog/repeater_cfg_pkg.sv ***
// Constants for the repeater channel configuration register slice
// Operation
// R1: De-emphasis code bits 2:0, reset -3.5 dB
// R2: Threshold bit 7 enables slow out-of-band detect
// R3: Assert level bits 3:2, default 180 mV
// R4: De-assert level bits 1:0, default 110 mV
// R5: Idle control bit 5 gives auto idle
// R6: Idle control bit 4 gives forced idle
// R7: Equalizer boost byte, fully writable, reset 0x2F
// R8: Control register resets 0x82, top bits 100
// R9: Software writes zero to reserved override bits
// R10: Threshold override selects register, else pin
// R11: Idle override forces idle, else normal; code passes bits 5:4 under override, else holds both idle outputs low
// R12: Fields hold last write until reset/load
`default_nettype none
package repeater_cfg_pkg;
  // Register offsets
  localparam logic [7:0] CTRL_A_OFS = 8'h11;
  localparam logic [7:0] THR_A_OFS = 8'h12;
  localparam logic [7:0] ANA_B_OFS = 8'h13;
  localparam logic [7:0] SPARE_B_OFS = 8'h14;
  localparam logic [7:0] IDLE_B_OFS = 8'h15;
  localparam logic [7:0] EQ_B_OFS = 8'h16;
  // Reset values
  localparam logic [7:0] CTRL_A_RST = 8'h82;
  localparam logic [7:0] THR_A_RST = 8'h00;
  localparam logic [7:0] ANA_B_RST = 8'h00;
  localparam logic [7:0] SPARE_B_RST = 8'h00;
  localparam logic [7:0] IDLE_B_RST = 8'h00;
  localparam logic [7:0] EQ_B_RST = 8'h2F;
  localparam logic [7:0] UNMAPPED_DATA = 8'h00;
  // Control register fields
  localparam int DEM_MSB = 2;
  localparam int DEM_LSB = 0;
  localparam logic [2:0] DEM_RST = 3'h2;
  localparam int CTRL_RW_MSB = 4;
  localparam int CTRL_RO_MSB = 7;
  localparam int CTRL_RO_LSB = 5;
  localparam logic [2:0] CTRL_RO_VAL = 3'h4;
  // Threshold register fields
  localparam int OOB_BIT = 7;
  localparam int ASSERT_MSB = 3;
  localparam int ASSERT_LSB = 2;
  localparam int DEASSERT_MSB = 1;
  localparam int DEASSERT_LSB = 0;
  localparam logic [1:0] LEVEL_DEFAULT = 2'h0;
  // Idle control fields
  localparam int AUTO_BIT = 5;
  localparam int FORCE_BIT = 4;
  // Global override bit positions, register held outside this slice
  localparam int GLOBAL_OVR_TH_BIT = 6;
  localparam int GLOBAL_OVR_IDLE_BIT = 4;
endpackage
`default_nettype wire

// *** verilog/repeater_channel_config_regs.sv ***
// Channel A/B configuration registers of a two-channel repeater
`timescale 1ns/1ps
`default_nettype none
module repeater_channel_config_regs (
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  // Management register port
  input wire logic [7:0] REG_ADDR_I,
  input wire logic REG_WR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic REG_RD_I,
  output logic [7:0] REG_RDATA_O,
  output logic REG_RVALID_O,
  // Configuration memory load port
  input wire logic LOAD_WR_I,
  input wire logic [7:0] LOAD_ADDR_I,
  input wire logic [7:0] LOAD_DATA_I,
  // Global override bits from the pin override register
  input wire logic OVR_IDLE_THRESHOLD_I,
  input wire logic OVR_IDLE_I,
  // Threshold select pin, asynchronous
  input wire logic SIGNAL_DETECT_LEVEL_PIN_I,
  // Channel A analog settings
  output logic [2:0] DEEMPHASIS_LEVEL_A_O,
  output logic SLOW_OUT_OF_BAND_DETECT_A_O,
  output logic [1:0] IDLE_ASSERT_LEVEL_A_O,
  output logic [1:0] IDLE_DEASSERT_LEVEL_A_O,
  output logic IDLE_LEVEL_FROM_REG_A_O,
  output logic SIGNAL_DETECT_LEVEL_O,
  // Channel B analog settings
  output logic AUTO_IDLE_B_O,
  output logic FORCE_IDLE_B_O,
  output logic [7:0] EQ_BOOST_B_O
);
  // Stored register contents
  logic [repeater_cfg_pkg::CTRL_RW_MSB:0] ctrl_a;
  logic [7:0] thr_a;
  logic [7:0] ana_b;
  logic [7:0] spare_b;
  logic [7:0] idle_b;
  logic [7:0] eq_b;
  // Pin synchroniser
  logic pin_meta;
  logic pin_sync;
  // Read path
  logic [7:0] next_rdata;

  idle_gate_if gate_bus ();

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction

  // Management writes take precedence over a simultaneous load
  wire wr_en = REG_WR_I | LOAD_WR_I;
  wire [7:0] wr_addr = REG_WR_I ? REG_ADDR_I : LOAD_ADDR_I;
  wire [7:0] wr_data = REG_WR_I ? REG_WDATA_I : LOAD_DATA_I;

  wire wr_ctrl_a = wr_en & hit(wr_addr, repeater_cfg_pkg::CTRL_A_OFS);
  wire wr_thr_a = wr_en & hit(wr_addr, repeater_cfg_pkg::THR_A_OFS);
  wire wr_ana_b = wr_en & hit(wr_addr, repeater_cfg_pkg::ANA_B_OFS);
  wire wr_spare_b = wr_en & hit(wr_addr, repeater_cfg_pkg::SPARE_B_OFS);
  wire wr_idle_b = wr_en & hit(wr_addr, repeater_cfg_pkg::IDLE_B_OFS);
  wire wr_eq_b = wr_en & hit(wr_addr, repeater_cfg_pkg::EQ_B_OFS);

  wire rd_ctrl_a = hit(REG_ADDR_I, repeater_cfg_pkg::CTRL_A_OFS);
  wire rd_thr_a = hit(REG_ADDR_I, repeater_cfg_pkg::THR_A_OFS);
  wire rd_ana_b = hit(REG_ADDR_I, repeater_cfg_pkg::ANA_B_OFS);
  wire rd_spare_b = hit(REG_ADDR_I, repeater_cfg_pkg::SPARE_B_OFS);
  wire rd_idle_b = hit(REG_ADDR_I, repeater_cfg_pkg::IDLE_B_OFS);
  wire rd_eq_b = hit(REG_ADDR_I, repeater_cfg_pkg::EQ_B_OFS);

  // Upper control bits are fixed read-only
  wire [7:0] ctrl_a_view = {repeater_cfg_pkg::CTRL_RO_VAL, ctrl_a}; // [R8]

  assign next_rdata =
    rd_ctrl_a ? ctrl_a_view :
    rd_thr_a ? thr_a :
    rd_ana_b ? ana_b :
    rd_spare_b ? spare_b :
    rd_idle_b ? idle_b :
    rd_eq_b ? eq_b :
    repeater_cfg_pkg::UNMAPPED_DATA; // [R12]

  // Channel A control: reserved bits 4:3 and de-emphasis code
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      ctrl_a <= repeater_cfg_pkg::CTRL_A_RST[repeater_cfg_pkg::CTRL_RW_MSB:0]; // [R1] [R8]
    end else if (wr_ctrl_a) begin
      ctrl_a <= wr_data[repeater_cfg_pkg::CTRL_RW_MSB:0]; // [R1] [R12]
    end
  end

  // Channel A idle threshold
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      thr_a <= repeater_cfg_pkg::THR_A_RST; // [R2]
    end else if (wr_thr_a) begin
      thr_a <= wr_data; // [R2] [R12]
    end
  end

  // Channel B analog override, reserved content kept as written
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      ana_b <= repeater_cfg_pkg::ANA_B_RST;
    end else if (wr_ana_b) begin
      ana_b <= wr_data; // [R9] [R12]
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      spare_b <= repeater_cfg_pkg::SPARE_B_RST;
    end else if (wr_spare_b) begin
      spare_b <= wr_data; // [R12]
    end
  end

  // Channel B idle control
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      idle_b <= repeater_cfg_pkg::IDLE_B_RST;
    end else if (wr_idle_b) begin
      idle_b <= wr_data; // [R12]
    end
  end

  // Channel B equalizer boost, all bits writable
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      eq_b <= repeater_cfg_pkg::EQ_B_RST; // [R7]
    end else if (wr_eq_b) begin
      eq_b <= wr_data; // [R7] [R12]
    end
  end

  // Read data is registered and answered one cycle later
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      REG_RDATA_O <= repeater_cfg_pkg::UNMAPPED_DATA;
      REG_RVALID_O <= 1'b0;
    end else begin
      REG_RVALID_O <= REG_RD_I;
      if (REG_RD_I) begin
        REG_RDATA_O <= next_rdata;
      end
    end
  end

  // Two-flop synchroniser for the threshold select pin
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
    end else begin
      pin_meta <= SIGNAL_DETECT_LEVEL_PIN_I;
      pin_sync <= pin_meta;
    end
  end

  // Override gating lives in the gate module
  assign gate_bus.ovr_th = OVR_IDLE_THRESHOLD_I; // [R10]
  assign gate_bus.ovr_idle = OVR_IDLE_I; // [R11]
  assign gate_bus.pin_level = pin_sync;
  assign gate_bus.assert_raw = thr_a[repeater_cfg_pkg::ASSERT_MSB:repeater_cfg_pkg::ASSERT_LSB]; // [R3]
  assign gate_bus.deassert_raw = thr_a[repeater_cfg_pkg::DEASSERT_MSB:repeater_cfg_pkg::DEASSERT_LSB]; // [R4]
  assign gate_bus.auto_raw = idle_b[repeater_cfg_pkg::AUTO_BIT]; // [R5]
  assign gate_bus.force_raw = idle_b[repeater_cfg_pkg::FORCE_BIT]; // [R6]

  idle_override_gate u_gate (
    .clk_i(SYS_CLK_I),
    .rst_i(RST_I),
    .g(gate_bus.gate)
  );

  // Outputs straight from storage flops, idle fields from the gate module flops
  assign DEEMPHASIS_LEVEL_A_O = ctrl_a[repeater_cfg_pkg::DEM_MSB:repeater_cfg_pkg::DEM_LSB]; // [R1]
  assign SLOW_OUT_OF_BAND_DETECT_A_O = thr_a[repeater_cfg_pkg::OOB_BIT]; // [R2]
  assign EQ_BOOST_B_O = eq_b; // [R7]
  assign IDLE_ASSERT_LEVEL_A_O = gate_bus.assert_lvl;
  assign IDLE_DEASSERT_LEVEL_A_O = gate_bus.deassert_lvl;
  assign IDLE_LEVEL_FROM_REG_A_O = gate_bus.from_reg;
  assign SIGNAL_DETECT_LEVEL_O = gate_bus.pin_out;
  assign AUTO_IDLE_B_O = gate_bus.auto_idle;
  assign FORCE_IDLE_B_O = gate_bus.force_idle;

  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (RST_I);

  sequence s_boost_write;
    REG_WR_I && REG_ADDR_I == 8'h16;
  endsequence

  sequence s_boost_read;
    REG_RD_I && !REG_WR_I && !LOAD_WR_I && REG_ADDR_I == 8'h16;
  endsequence

  sequence s_ctrl_read;
    REG_RD_I && REG_ADDR_I == 8'h11;
  endsequence

  a_dem_reset: assert property (disable iff (1'b0) RST_I |=> DEEMPHASIS_LEVEL_A_O == 3'h2) // [R1]
    else $error("de-emphasis code not -3.5 dB after reset");
  a_dem_write: assert property (REG_WR_I && REG_ADDR_I == 8'h11 // [R1]
    |=> DEEMPHASIS_LEVEL_A_O == $past(REG_WDATA_I[2:0]))
    else $error("de-emphasis write not stored");
  a_ctrl_fixed: assert property (s_ctrl_read |=> REG_RVALID_O && REG_RDATA_O[7:5] == 3'h4) // [R8]
    else $error("control upper bits do not read 100");
  a_thr_reset: assert property (disable iff (1'b0) RST_I // [R2]
    |=> !SLOW_OUT_OF_BAND_DETECT_A_O && thr_a == 8'h00)
    else $error("threshold register not zero after reset");
  a_oob_write: assert property (REG_WR_I && REG_ADDR_I == 8'h12 // [R2]
    |=> SLOW_OUT_OF_BAND_DETECT_A_O == $past(REG_WDATA_I[7]))
    else $error("slow out-of-band enable not stored");
  a_eq_reset: assert property (disable iff (1'b0) RST_I |=> EQ_BOOST_B_O == 8'h2F) // [R7]
    else $error("boost not 0x2F after reset");
  a_boost_readback: assert property (s_boost_write ##1 s_boost_read // [R12]
    |=> REG_RDATA_O == $past(REG_WDATA_I, 2))
    else $error("boost read back differs from last write");
  a_hold_idle: assert property (!wr_idle_b |=> idle_b == $past(idle_b)) // [R12]
    else $error("idle control changed without a write");
  a_idle_path: assert property (OVR_IDLE_I && !wr_idle_b ##1 OVR_IDLE_I // [R6] [R11]
    |=> FORCE_IDLE_B_O == $past(idle_b[4]))
    else $error("forced idle does not track register under override");
  a_thr_path: assert property (OVR_IDLE_THRESHOLD_I // [R3] [R10]
    |=> IDLE_LEVEL_FROM_REG_A_O && IDLE_ASSERT_LEVEL_A_O == $past(thr_a[3:2]))
    else $error("register thresholds not selected under override");

  // Read port handshake and unmapped reads
  sequence s_any_read;
    REG_RD_I;
  endsequence

  sequence s_unmapped_read;
    REG_RD_I && (REG_ADDR_I < repeater_cfg_pkg::CTRL_A_OFS || REG_ADDR_I > repeater_cfg_pkg::EQ_B_OFS);
  endsequence

  a_rvalid_pulse: assert property (s_any_read |=> REG_RVALID_O) // [R12]
    else $error("read strobe not answered one cycle later");
  a_rvalid_quiet: assert property (!REG_RD_I |=> !REG_RVALID_O) // [R12]
    else $error("read valid without a read strobe");
  a_rdata_hold: assert property (!REG_RD_I |=> $stable(REG_RDATA_O)) // [R12]
    else $error("read data changed without a read");
  a_unmapped_read: assert property (s_unmapped_read // [R12]
    |=> REG_RDATA_O == repeater_cfg_pkg::UNMAPPED_DATA)
    else $error("unmapped read returned nonzero data");
  a_ctrl_readback: assert property (s_ctrl_read // [R12]
    |=> REG_RDATA_O[repeater_cfg_pkg::CTRL_RW_MSB:0] == $past(ctrl_a))
    else $error("control read back differs from stored bits");

  // Loads land like writes while the management port is idle
  sequence s_boost_load;
    LOAD_WR_I && !REG_WR_I && LOAD_ADDR_I == repeater_cfg_pkg::EQ_B_OFS;
  endsequence

  sequence s_ctrl_load;
    LOAD_WR_I && !REG_WR_I && LOAD_ADDR_I == repeater_cfg_pkg::CTRL_A_OFS;
  endsequence

  a_eq_write: assert property (REG_WR_I && REG_ADDR_I == repeater_cfg_pkg::EQ_B_OFS // [R7]
    |=> EQ_BOOST_B_O == $past(REG_WDATA_I))
    else $error("boost write not stored in full");
  a_eq_load: assert property (s_boost_load |=> EQ_BOOST_B_O == $past(LOAD_DATA_I)) // [R12]
    else $error("boost load not stored");
  a_dem_load: assert property (s_ctrl_load // [R1]
    |=> DEEMPHASIS_LEVEL_A_O == $past(LOAD_DATA_I[repeater_cfg_pkg::DEM_MSB:repeater_cfg_pkg::DEM_LSB]))
    else $error("de-emphasis load not stored");

  // Stored fields change only on a decoded write
  a_hold_ctrl: assert property (!wr_ctrl_a |=> ctrl_a == $past(ctrl_a)) // [R12]
    else $error("control changed without a write");
  a_hold_thr: assert property (!wr_thr_a |=> thr_a == $past(thr_a)) // [R12]
    else $error("threshold changed without a write");
  a_hold_override: assert property (!wr_ana_b |=> ana_b == $past(ana_b)) // [R12]
    else $error("analog override changed without a write");
  a_hold_spare: assert property (!wr_spare_b |=> spare_b == $past(spare_b)) // [R12]
    else $error("spare register changed without a write");
  a_hold_boost: assert property (!wr_eq_b |=> eq_b == $past(eq_b)) // [R7]
    else $error("boost changed without a write");

  // Gated outputs trail their sources by one edge
  a_auto_path: assert property (OVR_IDLE_I // [R5]
    |=> AUTO_IDLE_B_O == $past(idle_b[repeater_cfg_pkg::AUTO_BIT]))
    else $error("auto idle does not track register under override");
  a_idle_off: assert property (!OVR_IDLE_I |=> !AUTO_IDLE_B_O && !FORCE_IDLE_B_O) // [R11]
    else $error("idle outputs active without override");
  a_deassert_path: assert property (OVR_IDLE_THRESHOLD_I // [R4]
    |=> IDLE_DEASSERT_LEVEL_A_O == $past(thr_a[repeater_cfg_pkg::DEASSERT_MSB:repeater_cfg_pkg::DEASSERT_LSB]))
    else $error("register de-assert level not selected under override");
  a_level_default: assert property (!OVR_IDLE_THRESHOLD_I // [R10]
    |=> !IDLE_LEVEL_FROM_REG_A_O && IDLE_ASSERT_LEVEL_A_O == repeater_cfg_pkg::LEVEL_DEFAULT
    && IDLE_DEASSERT_LEVEL_A_O == repeater_cfg_pkg::LEVEL_DEFAULT)
    else $error("pin control not selected without override");

  // Three clean edges flush the synchroniser and the gate flop
  sequence s_sync_settled;
    !RST_I ##1 !RST_I ##1 !RST_I;
  endsequence

  a_pin_path: assert property (s_sync_settled // [R10]
    |=> SIGNAL_DETECT_LEVEL_O == $past(SIGNAL_DETECT_LEVEL_PIN_I, 3))
    else $error("select pin level not passed on after synchroniser");
endmodule // repeater_channel_config_regs
`default_nettype wire
